// File: core/system_setup_word_decoder.v
// Purpose: decodes framed 29-bit commands into the device-wide setup register
// Assumes: word and strobe come from the serial framer on clk_sys_i
// Notes:   reserved encodings are ignored, no error is flagged
// Overview of operation
// - setup written only when channel and kind zero
// - one shared setup register per device
// - bit 28 low writes, high starts readback
// - bits 21..18 are per-channel clamp enables
// - channel register also writes same clamp state
// - readback shows latest clamp write, either path, from before the read cycle
// - bits 17..14 comparator outputs, high-Z after reset
// - lower bits: power, ground, alarms, guard, gain, thermal
// - comparator power defaults off, bit controls all
// - guard amplifier off until bit set
`timescale 1ns/1ps
`default_nettype none
`include "setup_word_defines.vh"

module system_setup_word_decoder (
    // clock and reset
    input  wire                    clk_sys_i,
    input  wire                    reset_i,
    // framed command from the serial receiver
    input  wire                    word_valid_i,
    input  wire [`CMD_W-1:0]       word_i,
    // per-channel clamp write from the channel register decoder
    input  wire [3:0]              chan_clamp_wr_i,
    input  wire                    chan_clamp_val_i,
    // readback
    output reg                     rdback_valid_o,
    output reg  [`SETUP_W-1:0]     rdback_data_o,
    // setup fields
    output wire [3:0]              clamp_on_o,
    output wire [3:0]              cmp_out_on_o,
    output wire [3:0]              cmp_out_oe_o,
    output wire                    cmp_power_on_o,
    output wire                    per_channel_ground_select_o,
    output wire                    guard_alarm_route_o,
    output wire                    clamp_alarm_route_o,
    output wire                    internal_sense_short_o,
    output wire                    guard_amp_on_o,
    output wire [1:0]              measure_gain_o,
    output wire                    thermal_shutdown_on_o,
    output wire [1:0]              thermal_limit_o,
    output wire                    alarm_latched_o
);

    // =====================================================
    // command decode
    // =====================================================
    function is_setup_addr;
        input [`CMD_W-1:0] w;
        begin
            is_setup_addr = (w[`CMD_CHSEL_HI:`CMD_CHSEL_LO] == `CHSEL_NONE) &&
                            (w[`CMD_KIND_HI:`CMD_KIND_LO] == `KIND_SETUP);
        end
    endfunction

    // =====================================================
    // field extraction, shared by the pins and the readback image
    // =====================================================
    function [3:0] clamp_bits;
        input [`SETUP_W-1:0] q;
        begin
            clamp_bits = q[`SETUP_CLAMP_HI:`SETUP_CLAMP_LO];
        end
    endfunction

    function [3:0] cmpout_bits;
        input [`SETUP_W-1:0] q;
        begin
            cmpout_bits = q[`SETUP_CMPOUT_HI:`SETUP_CMPOUT_LO];
        end
    endfunction

    function cmp_power_bit;
        input [`SETUP_W-1:0] q;
        begin
            cmp_power_bit = q[`SETUP_CMPPWR];
        end
    endfunction

    function gnd_select_bit;
        input [`SETUP_W-1:0] q;
        begin
            gnd_select_bit = q[`SETUP_GNDSEL];
        end
    endfunction

    function guard_alarm_bit;
        input [`SETUP_W-1:0] q;
        begin
            guard_alarm_bit = q[`SETUP_GUARD_ALM];
        end
    endfunction

    function clamp_alarm_bit;
        input [`SETUP_W-1:0] q;
        begin
            clamp_alarm_bit = q[`SETUP_CLAMP_ALM];
        end
    endfunction

    function sense_short_bit;
        input [`SETUP_W-1:0] q;
        begin
            sense_short_bit = q[`SETUP_SENSE_SHT];
        end
    endfunction

    function guard_en_bit;
        input [`SETUP_W-1:0] q;
        begin
            guard_en_bit = q[`SETUP_GUARD_EN];
        end
    endfunction

    function [1:0] gain_bits;
        input [`SETUP_W-1:0] q;
        begin
            gain_bits = q[`SETUP_GAIN_HI:`SETUP_GAIN_LO];
        end
    endfunction

    function thermal_en_bit;
        input [`SETUP_W-1:0] q;
        begin
            thermal_en_bit = q[`SETUP_TMP_EN];
        end
    endfunction

    function [1:0] thermal_limit_bits;
        input [`SETUP_W-1:0] q;
        begin
            thermal_limit_bits = q[`SETUP_TMP_HI:`SETUP_TMP_LO];
        end
    endfunction

    function latched_bit;
        input [`SETUP_W-1:0] q;
        begin
            latched_bit = q[`SETUP_LATCHED];
        end
    endfunction

    // image rebuilt from the same extractions, so readback matches the field pins
    // as they stood before the read cycle; unused bits always read low
    function [`SETUP_W-1:0] setup_image;
        input [`SETUP_W-1:0] q;
        begin
            setup_image = {clamp_bits(q),
                           cmpout_bits(q),
                           cmp_power_bit(q),
                           gnd_select_bit(q),
                           guard_alarm_bit(q),
                           clamp_alarm_bit(q),
                           sense_short_bit(q),
                           guard_en_bit(q),
                           gain_bits(q),
                           thermal_en_bit(q),
                           thermal_limit_bits(q),
                           latched_bit(q),
                           `SETUP_UNUSED_FILL};
        end
    endfunction

    wire addr_hit;
    wire setup_wr;
    wire setup_rd;
    wire [`SETUP_W-1:0] setup_q;

    assign addr_hit = is_setup_addr(word_i);
    // only a framed word acts, so no partial shift is ever seen
    assign setup_wr = word_valid_i && addr_hit && !word_i[`CMD_RW_BIT];
    assign setup_rd = word_valid_i && addr_hit && word_i[`CMD_RW_BIT];

    // =====================================================
    // shared register, single instance
    // =====================================================
    setup_field_store u_store (
        .clk_sys_i        (clk_sys_i),
        .reset_i          (reset_i),
        .setup_wr_i       (setup_wr),
        .setup_data_i     (word_i[`SETUP_W-1:0]),
        .chan_clamp_wr_i  (chan_clamp_wr_i),
        .chan_clamp_val_i (chan_clamp_val_i),
        .setup_q_o        (setup_q)
    );

    // =====================================================
    // readback
    // =====================================================
    // sampled from the stored value, so a clamp write of either path in the read cycle does not show
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rdback_valid_o <= 1'b0;
            rdback_data_o  <= `SETUP_RESET;
        end else begin
            rdback_valid_o <= setup_rd;
            if (setup_rd) begin
                rdback_data_o <= setup_image(setup_q);
            end
        end
    end

    // =====================================================
    // field outputs
    // =====================================================
    assign clamp_on_o                  = clamp_bits(setup_q);
    assign cmp_out_on_o                = cmpout_bits(setup_q);
    // comparator pins float until enabled
    assign cmp_out_oe_o                = cmpout_bits(setup_q);
    assign cmp_power_on_o              = cmp_power_bit(setup_q);
    assign per_channel_ground_select_o = gnd_select_bit(setup_q);
    assign guard_alarm_route_o         = guard_alarm_bit(setup_q);
    assign clamp_alarm_route_o         = clamp_alarm_bit(setup_q);
    assign internal_sense_short_o      = sense_short_bit(setup_q);
    assign guard_amp_on_o              = guard_en_bit(setup_q);
    assign measure_gain_o              = gain_bits(setup_q);
    assign thermal_shutdown_on_o       = thermal_en_bit(setup_q);
    assign thermal_limit_o             = thermal_limit_bits(setup_q);
    assign alarm_latched_o             = latched_bit(setup_q);

endmodule
`default_nettype wire

// File: core/setup_word_defines.vh
// Purpose: constants for the device-wide setup word decoder
// Assumes: 29-bit command words, bit 28 first in the word layout
// Notes:   field positions are bit indices into the command word
`ifndef SETUP_WORD_DEFINES_VH
`define SETUP_WORD_DEFINES_VH

`define CMD_W            29
`define CMD_RW_BIT       28
`define CMD_CHSEL_HI     27
`define CMD_CHSEL_LO     24
`define CMD_KIND_HI      23
`define CMD_KIND_LO      22
`define SETUP_W          22
`define SETUP_CLAMP_HI   21
`define SETUP_CLAMP_LO   18
`define SETUP_CMPOUT_HI  17
`define SETUP_CMPOUT_LO  14
`define SETUP_CMPPWR     13
`define SETUP_GNDSEL     12
`define SETUP_GUARD_ALM  11
`define SETUP_CLAMP_ALM  10
`define SETUP_SENSE_SHT  9
`define SETUP_GUARD_EN   8
`define SETUP_GAIN_HI    7
`define SETUP_GAIN_LO    6
`define SETUP_TMP_EN     5
`define SETUP_TMP_HI     4
`define SETUP_TMP_LO     3
`define SETUP_LATCHED    2
`define SETUP_UNUSED_HI  1
`define SETUP_UNUSED_LO  0
`define SETUP_RESET      22'h000000
`define CHSEL_NONE       4'h0
`define KIND_SETUP       2'h0
`define CHAN_N           4
`define SETUP_UNUSED_FILL 2'h0

`endif

// File: core/setup_field_store.v
// Purpose: holds the shared setup fields, one instance per device
// Assumes: write strobes come from the command decoder on clk_sys_i
// Notes:   clamp enables have two writers; the channel strobe wins per channel when both arrive in one cycle
`timescale 1ns/1ps
`default_nettype none
`include "setup_word_defines.vh"

module setup_field_store (
    // clock and reset
    input  wire                    clk_sys_i,
    input  wire                    reset_i,
    // device-wide write
    input  wire                    setup_wr_i,
    input  wire [`SETUP_W-1:0]     setup_data_i,
    // per-channel clamp write
    input  wire [3:0]              chan_clamp_wr_i,
    input  wire                    chan_clamp_val_i,
    // stored state
    output reg  [`SETUP_W-1:0]     setup_q_o
);

    integer i;
    reg [`SETUP_W-1:0] setup_nxt;

    always @* begin
        setup_nxt = setup_q_o;
        if (setup_wr_i) begin
            setup_nxt = setup_data_i;
            // unused bits always stored as zero
            setup_nxt[`SETUP_UNUSED_HI:`SETUP_UNUSED_LO] = 2'h0;
        end
        // same clamp state written by the channel path
        for (i = 0; i < `CHAN_N; i = i + 1) begin
            if (chan_clamp_wr_i[i]) begin
                setup_nxt[`SETUP_CLAMP_LO + i] = chan_clamp_val_i;
            end
        end
    end

    // all enables off, comparators unpowered, guard off at reset
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            setup_q_o <= `SETUP_RESET;
        end else begin
            setup_q_o <= setup_nxt;
        end
    end

endmodule
`default_nettype wire

// File: bench/setup_word_checker_asserts.sv
// Purpose: port assertions for the setup word decoder
// Assumes: one clock domain, async active-high reset
// Notes:   clamp bits are left to the bench where strobes collide
`timescale 1ns/1ps
`default_nettype none
// ====================
// checker
module setup_word_checker (
    input wire logic        clk_sys_i, reset_i, word_valid_i, chan_clamp_val_i,
    input wire logic [28:0] word_i,
    input wire logic [3:0]  chan_clamp_wr_i, clamp_on_o, cmp_out_on_o, cmp_out_oe_o,
    input wire logic        rdback_valid_o, cmp_power_on_o, guard_amp_on_o,
    input wire logic [21:0] rdback_data_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    wire wr = word_valid_i && word_i[28:22] == 7'h00;
    write_apply_a: assert property (wr |=> cmp_out_on_o == $past(word_i[17:14]))
        else $error("setup write lost");
    other_ignore_a: assert property (word_valid_i && word_i[27:22] != 6'h00
        |=> $stable({cmp_out_on_o, cmp_power_on_o, guard_amp_on_o})) else $error("foreign write");
    read_pulse_a: assert property (word_valid_i && word_i[28:22] == 7'h40 |=> rdback_valid_o)
        else $error("no readback");
    no_read_a: assert property (!(word_valid_i && word_i[28]) |=> !rdback_valid_o)
        else $error("stray readback");
    clamp_path_a: assert property (chan_clamp_wr_i[2]
        |=> clamp_on_o[2] == $past(chan_clamp_val_i)) else $error("clamp strobe lost");
    oe_match_a: assert property (cmp_out_oe_o == cmp_out_on_o &&
        (cmp_out_oe_o == $past(cmp_out_oe_o) || $past(wr))) else $error("compare drive mismatch");
    power_guard_a: assert property (wr |=> {cmp_power_on_o, guard_amp_on_o}
        == {$past(word_i[13]), $past(word_i[8])}) else $error("power or guard wrong");
    unused_zero_a: assert property (rdback_valid_o |-> rdback_data_o[1:0] == 2'h0)
        else $error("unused bits read back");
    cover property (wr);
    cover property (rdback_valid_o);
    cover property (chan_clamp_wr_i != 4'h0);
    cover property (wr && chan_clamp_wr_i != 4'h0);
endmodule
bind system_setup_word_decoder setup_word_checker setup_word_checker_inst (.clk_sys_i, .reset_i,
    .word_valid_i, .chan_clamp_val_i, .word_i, .chan_clamp_wr_i, .clamp_on_o, .cmp_out_on_o,
    .cmp_out_oe_o, .rdback_valid_o, .cmp_power_on_o, .guard_amp_on_o, .rdback_data_o);
`default_nettype wire

// File: bench/host_model.sv
// Purpose: host side that frames command words
// Assumes: bench sends only assigned encodings unless testing refusal
// Notes:   idle word lines invert so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
// ====================
// host
module host_model (
    input  wire logic        clk_sys_i,
    input  wire logic        send_i,
    input  wire logic [28:0] cmd_i,
    output var  logic        word_valid_o,
    output var  logic [28:0] word_o
);
    always @(posedge clk_sys_i) begin
        word_valid_o <= send_i;
        word_o       <= send_i ? cmd_i : ~word_o;
    end
endmodule
`default_nettype wire

// File: bench/system_setup_word_decoder_tb_top.sv
// Purpose: self-checking bench for the setup word decoder
// Assumes: host model adds one cycle before the decoder
// Notes:   bits 1:0 and foreign encodings are sent on purpose several times
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench
module system_setup_word_decoder_tb_top;
    logic        clk_sys_i = 1'b0, reset_i = 1'b1, send = 1'b0, cv = 1'b0, rv, wv, pwr, grd;
    logic [28:0] cmd = 29'h0, w;
    logic        gnd, galm, calm, sense, tmp_en, latched;
    logic [1:0]  gain, tmp_lim;
    logic [3:0]  cw = 4'h0, clamp, cmp_on, cmp_oe;
    logic [21:0] rd, fld;
    int          mismatches = 0, tests_run = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    host_model host_model_inst (.clk_sys_i, .send_i(send), .cmd_i(cmd), .word_valid_o(wv),
        .word_o(w));
    system_setup_word_decoder system_setup_word_decoder_inst (.clk_sys_i, .reset_i,
        .word_valid_i(wv), .word_i(w), .chan_clamp_wr_i(cw), .chan_clamp_val_i(cv),
        .rdback_valid_o(rv), .rdback_data_o(rd), .clamp_on_o(clamp), .cmp_out_on_o(cmp_on),
        .cmp_out_oe_o(cmp_oe), .cmp_power_on_o(pwr), .per_channel_ground_select_o(gnd),
        .guard_alarm_route_o(galm), .clamp_alarm_route_o(calm), .internal_sense_short_o(sense),
        .guard_amp_on_o(grd), .measure_gain_o(gain), .thermal_shutdown_on_o(tmp_en),
        .thermal_limit_o(tmp_lim), .alarm_latched_o(latched));
    assign fld = {clamp, cmp_on, pwr, gnd, galm, calm, sense, grd, gain, tmp_en, tmp_lim, latched,
        2'h0};
    task automatic results;
        if (mismatches == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [21:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic send_cmd(input logic [28:0] c);
        @(posedge clk_sys_i) begin send <= 1'b1; cmd <= c; end
        @(posedge clk_sys_i) send <= 1'b0;
        @(posedge clk_sys_i) #1;
    endtask
    task automatic read_chk(input logic [21:0] exp);
        int i;
        @(posedge clk_sys_i) begin send <= 1'b1; cmd <= 29'h10000000; end
        @(posedge clk_sys_i) send <= 1'b0;
        for (i = 0; i < 8 && rv !== 1'b1; i++) @(posedge clk_sys_i) #1;
        if (rv !== 1'b1) begin
            chk("readback valid", 22'h000001, {21'h0, rv});
            results();
        end else chk("readback", exp, rd);
    endtask
    initial begin
        repeat (16) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        read_chk(22'h000000);
        send_cmd(29'h0002100);
        chk("power and guard", 22'h000003, {20'h0, pwr, grd});
        send_cmd(29'h029a9ad);
        chk("field pins", 22'h29a9ac, fld);
        read_chk(22'h29a9ac);
        send_cmd(29'h03fffff);
        read_chk(22'h3ffffc);
        chk("compare drive", 22'h00000f, {18'h0, cmp_oe});
        chk("all field pins", 22'h3ffffc, fld);
        send_cmd(29'h1000000);
        send_cmd(29'h1400000);
        read_chk(22'h3ffffc);
        @(posedge clk_sys_i) begin cw <= 4'h4; cv <= 1'b0; end
        @(posedge clk_sys_i) cw <= 4'h0;
        #1 chk("channel clamp", 22'h00000b, {18'h0, clamp});
        read_chk(22'h2ffffc);
        @(posedge clk_sys_i) begin send <= 1'b1; cmd <= 29'h03c0000; end
        @(posedge clk_sys_i) begin send <= 1'b0; cw <= 4'h1; end
        @(posedge clk_sys_i) cw <= 4'h0;
        #1 chk("clamp collision", 22'h00000e, {18'h0, clamp});
        read_chk(22'h380000);
        @(posedge clk_sys_i) reset_i <= 1'b1;
        @(posedge clk_sys_i) reset_i <= 1'b0;
        read_chk(22'h000000);
        send_cmd(29'h0ffffff);
        read_chk(22'h000000);
        send_cmd(29'h03fffff);
        send_cmd(29'h0000000);
        read_chk(22'h000000);
        results();
    end
endmodule
`default_nettype wire
